// >>> chip_fault_diagnostics.sv
/*
 * chip level fault supervision: thermal warning, over-temperature, supply
 * undervoltage, logic power-down and serial frame errors, with the
 * diagnostic flags and the open-drain active-low fault pin.
 * assumes the temperature comparator levels already carry their hysteresis and that all
 * inputs are synchronous to clk. rst is the power-on reset.
 */
`timescale 1ns/1ps
module chip_fault_diagnostics #(
	parameter int unsigned PULSE_PERIODS = fault_diag_pkg::PULSE_PERIODS,
	parameter int unsigned FRAME_BITS    = fault_diag_pkg::FRAME_BITS
) (
	// clock and power-on reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// analogue comparator levels
	input  wire fault_diag_pkg::sense_s sense,
	input  wire logic                  logic_reset_level,
	// configuration
	input  wire fault_diag_pkg::mask_s  mask,
	input  wire logic                  direct_mode,
	input  wire logic                  stop_on_fault_enable,
	// motor control input
	input  wire logic                  pwm_in,
	// serial frame pins and read qualifier
	input  wire logic                  sck,
	input  wire logic                  frame_select_n,
	input  wire logic                  diag_read_frame,
	// diagnostic register view
	output fault_diag_pkg::diag_s       diag,
	// fault pin, open drain
	output logic                       fault_out_n_o,
	output logic                       fault_out_n_oe,
	// bridge and motor control
	output logic                       gate_enable,
	output logic                       pwm_gated,
	output logic                       write_commit,
	output logic                       powered_down
);

	if (PULSE_PERIODS < 1 || FRAME_BITS < 1) begin : g_chk
		$error("chip_fault_diagnostics: bad parameters");
	end

	// ****************************************
	// state
	// ****************************************

	typedef struct packed {
		fault_diag_pkg::diag_s diag;
		logic                  uv_active;
		logic                  ot_active;
		logic                  tw_active;
		logic                  pin_low;
		logic                  gate_en;
		logic                  pwm_out;
		logic                  commit;
		logic                  down;
	} top_s;

	top_s state_ff;
	top_s nxt_state_ff;

	logic frame_ok;
	logic frame_err;
	logic pulse_low;
	logic pulse_req;
	logic steady_low;
	logic tw_now;
	logic ot_now;
	logic uv_now;
	logic ot_stop;
	logic read_clear;

	// ****************************************
	// helpers
	// ****************************************

	// serial frame judge, held in reset while the logic is powered down
	serial_frame_check #(
		.BITS (FRAME_BITS)
	) u_frame (
		.clk            (clk),
		.rst            (rst),
		.clear          (logic_reset_level),
		.sck            (sck),
		.frame_select_n (frame_select_n),
		.frame_ok       (frame_ok),
		.frame_err      (frame_err)
	);

	// pulse pattern shared by warning and over-temperature, both four periods
	pwm_pulse_gen #(
		.PERIODS (PULSE_PERIODS)
	) u_pulse (
		.clk       (clk),
		.rst       (rst),
		.clear     (logic_reset_level),
		.pwm_in    (pwm_in),
		.request   (pulse_req),
		.pulse_low (pulse_low)
	);

	// ****************************************
	// fault detection
	// ****************************************

	always_comb begin
		// masked monitors are fully blind
		tw_now = sense.thermal_warn && !mask.thermal_warn;
		ot_now = sense.overtemp && !mask.overtemp;
		uv_now = 1'b0;
		if (!mask.supply_undervoltage) begin
			if (state_ff.uv_active) begin
				uv_now = !sense.above_on;
			end else begin
				uv_now = sense.below_off;
			end
		end
		ot_stop = ot_now && (direct_mode || stop_on_fault_enable);
		// steady low level: released at once when the cause goes
		steady_low = uv_now
			|| ot_stop
			|| (tw_now && direct_mode);
		pulse_req = !direct_mode && (
			(ot_now && !stop_on_fault_enable)
			|| (tw_now && stop_on_fault_enable));
		// a complete error-free read frame of the diagnostic register
		read_clear = frame_ok && diag_read_frame;
	end

	// ****************************************
	// next state
	// ****************************************

	always_comb begin
		nxt_state_ff           = state_ff;
		nxt_state_ff.commit    = 1'b0;
		nxt_state_ff.down      = logic_reset_level;
		nxt_state_ff.uv_active = uv_now;
		nxt_state_ff.ot_active = ot_now;
		nxt_state_ff.tw_active = tw_now;

		// diagnostic clear first, so any event this cycle sets afterwards
		if (read_clear) begin
			nxt_state_ff.diag = '0;
		end
		if (frame_ok && !diag_read_frame) begin
			nxt_state_ff.commit = 1'b1;
		end
		if (frame_err) begin
			// error frames never clear and never write
			nxt_state_ff.diag.serial_error_flag  = 1'b1;
			nxt_state_ff.diag.general_fault_flag = 1'b1;
		end
		if (tw_now) begin
			nxt_state_ff.diag.thermal_warn_flag  = 1'b1;
			nxt_state_ff.diag.general_fault_flag = 1'b1;
		end
		if (ot_now) begin
			nxt_state_ff.diag.overtemp_flag      = 1'b1;
			nxt_state_ff.diag.general_fault_flag = 1'b1;
		end
		if (uv_now) begin
			nxt_state_ff.diag.supply_undervoltage_flag = 1'b1;
			nxt_state_ff.diag.general_fault_flag       = 1'b1;
		end

		// gate drives: warning never stops them, undervoltage stops both, stop only the enable
		nxt_state_ff.gate_en = !uv_now && !ot_stop;
		nxt_state_ff.pwm_out = pwm_in && !uv_now;
		nxt_state_ff.pin_low = steady_low || pulse_low;

		// logic power-down: everything off, pin low, flags at power-on view
		if (logic_reset_level) begin
			nxt_state_ff.diag      = fault_diag_pkg::DIAG_RESET;
			nxt_state_ff.uv_active = 1'b0;
			nxt_state_ff.ot_active = 1'b0;
			nxt_state_ff.tw_active = 1'b0;
			nxt_state_ff.gate_en   = 1'b0;
			nxt_state_ff.pwm_out   = 1'b0;
			nxt_state_ff.commit    = 1'b0;
			nxt_state_ff.pin_low   = 1'b1;
		end
	end

	// ****************************************
	// registers
	// ****************************************

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= '{
				diag:    fault_diag_pkg::DIAG_RESET,
				pin_low: 1'b1,
				down:    1'b1,
				default: '0
			};
		end else begin
			state_ff <= nxt_state_ff;
		end
	end

	// ****************************************
	// outputs
	// ****************************************

	assign diag           = state_ff.diag;
	assign fault_out_n_o  = 1'b0;
	assign fault_out_n_oe = state_ff.pin_low;
	assign gate_enable    = state_ff.gate_en;
	assign pwm_gated      = state_ff.pwm_out;
	assign write_commit   = state_ff.commit;
	assign powered_down   = state_ff.down;

endmodule

// >>> fault_diag_pkg.sv
/*
 * shared constants, field layouts and state types of the chip fault
 * supervision block. assumes one 50 MHz clock and synchronous inputs.
 */
package fault_diag_pkg;

	localparam int unsigned PULSE_PERIODS = 4;
	localparam int unsigned FRAME_BITS    = 16;
	localparam int unsigned EDGE_CNT_W    = 5;

	// diagnostic register reset view: power-on and general fault set
	localparam logic RST_POR_FLAG  = 1'b1;
	localparam logic RST_GEN_FLAG  = 1'b1;

	typedef struct packed {
		logic por_flag;
		logic general_fault_flag;
		logic serial_error_flag;
		logic supply_undervoltage_flag;
		logic overtemp_flag;
		logic thermal_warn_flag;
	} diag_s;

	localparam diag_s DIAG_RESET = '{
		por_flag:           RST_POR_FLAG,
		general_fault_flag: RST_GEN_FLAG,
		default:            1'b0
	};

	typedef struct packed {
		logic thermal_warn;
		logic overtemp;
		logic supply_undervoltage;
	} mask_s;

	typedef struct packed {
		logic thermal_warn;   // above warning threshold (hysteresis outside)
		logic overtemp;       // above shutdown threshold
		logic below_off;      // supply under supply_off_level
		logic above_on;       // supply over supply_on_level
	} sense_s;

	typedef enum logic [1:0] {
		PULSE_IDLE,
		PULSE_LOW,
		PULSE_GAP
	} pulse_state_e;

endpackage

// >>> serial_frame_check.sv
/*
 * counts serial clock rising edges inside one frame and judges the frame
 * at its close. assumes sck and frame_select_n synchronous to clk.
 */
`timescale 1ns/1ps
module serial_frame_check #(
	parameter int unsigned BITS = fault_diag_pkg::FRAME_BITS
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic clear,
	// serial pins
	input  wire logic sck,
	input  wire logic frame_select_n,
	// verdict, one-cycle pulses
	output logic      frame_ok,
	output logic      frame_err
);

	localparam int unsigned CW = fault_diag_pkg::EDGE_CNT_W;

	if (BITS < 1 || BITS + 1 >= (1 << CW)) begin : g_chk
		$error("serial_frame_check: BITS out of range");
	end

	typedef struct packed {
		logic          sck_q;
		logic          sel_n_q;
		logic [CW-1:0] edges;
		logic          ok;
		logic          err;
	} frame_s;

	frame_s state_ff;
	frame_s nxt_state_ff;

	always_comb begin
		nxt_state_ff         = state_ff;
		nxt_state_ff.sck_q   = sck;
		nxt_state_ff.sel_n_q = frame_select_n;
		nxt_state_ff.ok      = 1'b0;
		nxt_state_ff.err     = 1'b0;
		if (state_ff.sel_n_q && !frame_select_n) begin
			nxt_state_ff.edges = '0;
		end else if (!frame_select_n && sck && !state_ff.sck_q) begin
			// saturate one above a full frame so overrun stays visible
			if (state_ff.edges <= CW'(BITS)) begin
				nxt_state_ff.edges = state_ff.edges + CW'(1);
			end
		end
		if (!state_ff.sel_n_q && frame_select_n) begin
			if (state_ff.edges == CW'(BITS)) begin
				nxt_state_ff.ok = 1'b1;
			end else begin
				nxt_state_ff.err = 1'b1;
			end
		end
		if (clear) begin
			nxt_state_ff = '{sck_q: sck, sel_n_q: 1'b1, default: '0};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= '{sel_n_q: 1'b1, default: '0};
		end else begin
			state_ff <= nxt_state_ff;
		end
	end

	assign frame_ok  = state_ff.ok;
	assign frame_err = state_ff.err;

endmodule

// >>> pwm_pulse_gen.sv
/*
 * fault pin pulse pattern: low for a number of PWM periods, then inactive
 * for as many, repeating while requested. assumes pwm_in synchronous.
 */
`timescale 1ns/1ps
module pwm_pulse_gen #(
	parameter int unsigned PERIODS = fault_diag_pkg::PULSE_PERIODS
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic clear,
	// timing source and request
	input  wire logic pwm_in,
	input  wire logic request,
	// pattern, high while the pin is to be pulled low
	output logic      pulse_low
);

	localparam int unsigned CW = $clog2(PERIODS + 1);

	if (PERIODS < 1) begin : g_chk
		$error("pwm_pulse_gen: PERIODS must be at least one");
	end

	typedef struct packed {
		logic                        pwm_q;
		fault_diag_pkg::pulse_state_e st;
		logic [CW-1:0]               periods;
	} pulse_s;

	pulse_s state_ff;
	pulse_s nxt_state_ff;
	logic   period_end;

	always_comb begin
		nxt_state_ff       = state_ff;
		nxt_state_ff.pwm_q = pwm_in;
		period_end = pwm_in && !state_ff.pwm_q;
		case (state_ff.st)
			fault_diag_pkg::PULSE_IDLE: begin
				nxt_state_ff.periods = '0;
				if (request) begin
					nxt_state_ff.st = fault_diag_pkg::PULSE_LOW;
				end
			end
			fault_diag_pkg::PULSE_LOW: begin
				if (period_end) begin
					nxt_state_ff.periods = state_ff.periods + CW'(1);
					if (state_ff.periods == CW'(PERIODS - 1)) begin
						nxt_state_ff.periods = '0;
						// a pulse already begun runs to its end
						nxt_state_ff.st = request ? fault_diag_pkg::PULSE_GAP
							: fault_diag_pkg::PULSE_IDLE;
					end
				end
			end
			fault_diag_pkg::PULSE_GAP: begin
				if (!request) begin
					nxt_state_ff.st = fault_diag_pkg::PULSE_IDLE;
				end else if (period_end) begin
					nxt_state_ff.periods = state_ff.periods + CW'(1);
					if (state_ff.periods == CW'(PERIODS - 1)) begin
						nxt_state_ff.periods = '0;
						nxt_state_ff.st = fault_diag_pkg::PULSE_LOW;
					end
				end
			end
			default: begin
				nxt_state_ff.st = fault_diag_pkg::PULSE_IDLE;
			end
		endcase
		if (clear) begin
			nxt_state_ff = '{pwm_q: pwm_in, st: fault_diag_pkg::PULSE_IDLE, default: '0};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= '{pwm_q: 1'b0, st: fault_diag_pkg::PULSE_IDLE, default: '0};
		end else begin
			state_ff <= nxt_state_ff;
		end
	end

	assign pulse_low = state_ff.st == fault_diag_pkg::PULSE_LOW;

endmodule

// >>> host_model.sv
/* host side: pwm source, serial frames, pull-up on the fault pin
   assumes one clk shared with the block; tasks called via hierarchy */
`timescale 1ns/1ps
module host_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// fault pin
	input  wire logic fault_out_n_o,
	input  wire logic fault_out_n_oe,
	output logic      fault_line,
	// host pins
	output logic      pwm_in = 1'b0,
	output logic      sck = 1'b0,
	output logic      frame_select_n = 1'b1,
	output logic      diag_read_frame = 1'b0
);
	int half = 2;

	// pull-up when nobody pulls low
	assign fault_line = fault_out_n_oe ? fault_out_n_o : 1'b1;

	always begin
		repeat (half) @(posedge clk);
		#1;
		pwm_in = ~pwm_in;
	end

	// ********
	// one frame of n clock edges
	// ********
	task automatic frame(input int n, input logic rd);
		@(posedge clk);
		#1;
		frame_select_n = 1'b0;
		diag_read_frame = rd;
		repeat (n) begin
			@(posedge clk);
			#1;
			sck = 1'b1;
			@(posedge clk);
			#1;
			sck = 1'b0;
		end
		@(posedge clk);
		#1;
		frame_select_n = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		// qualifier released: show the inverse
		diag_read_frame = ~rd;
	endtask
endmodule

// >>> fault_checker.sv
/* assertions on the fault block ports
   bound into chip_fault_diagnostics; one clock, rst async high */
`timescale 1ns/1ps
module fault_checker #(
	parameter int unsigned FRAME_BITS = 16
) (
	// clock and reset
	input wire logic                   clk,
	input wire logic                   rst,
	// inputs
	input wire fault_diag_pkg::sense_s sense,
	input wire fault_diag_pkg::mask_s  mask,
	input wire logic                   logic_reset_level,
	input wire logic                   direct_mode,
	input wire logic                   stop_on_fault_enable,
	input wire logic                   sck,
	input wire logic                   frame_select_n,
	input wire logic                   diag_read_frame,
	// outputs
	input wire fault_diag_pkg::diag_s  diag,
	input wire logic                   fault_out_n_oe,
	input wire logic                   gate_enable,
	input wire logic                   pwm_gated,
	input wire logic                   write_commit,
	input wire logic                   powered_down
);
	logic [4:0] cnt_ff;
	logic       sck_ff;
	logic       fsn_ff;
	logic       up;
	logic       ot_stop;

	assign up = !logic_reset_level;
	assign ot_stop = sense.overtemp && !mask.overtemp && up
		&& (direct_mode || stop_on_fault_enable);

	// ********
	// clock edges seen in the current frame
	// ********
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= 5'h0;
			sck_ff <= 1'b0;
			fsn_ff <= 1'b1;
		end else begin
			sck_ff <= sck;
			fsn_ff <= frame_select_n;
			if (!frame_select_n && fsn_ff)
				cnt_ff <= 5'h0;
			else if (!frame_select_n && sck && !sck_ff && cnt_ff < 5'h11)
				cnt_ff <= cnt_ff + 5'h1;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence uv_s;
		sense.below_off && !mask.supply_undervoltage && up;
	endsequence
	sequence end_s;
		$rose(frame_select_n) && up;
	endsequence
	sequence quiet_s;
		!sense.thermal_warn && !sense.overtemp && !sense.below_off && sense.above_on && up;
	endsequence

	uv_pin_a: assert property (
		uv_s |=> fault_out_n_oe && !gate_enable
	) else $error("uv pin");
	ot_stop_a: assert property (
		ot_stop |=> fault_out_n_oe && !gate_enable && diag.overtemp_flag
	) else $error("ot stop");
	gate_keep_a: assert property (
		gate_enable && up && !sense.below_off && !ot_stop |=> gate_enable
	) else $error("gate dropped");
	ot_mask_a: assert property (
		mask.overtemp && !diag.overtemp_flag && up |=> !diag.overtemp_flag
	) else $error("masked flag");
	frame_err_a: assert property (
		end_s ##0 cnt_ff != FRAME_BITS |-> ##1 !write_commit
			##1 !write_commit && diag.serial_error_flag && diag.general_fault_flag
	) else $error("frame error");
	frame_ok_a: assert property (
		end_s ##0 cnt_ff == FRAME_BITS && !diag_read_frame |-> ##2 write_commit
	) else $error("no commit");
	read_clear_a: assert property (
		quiet_s ##1 end_s ##0 quiet_s ##0 cnt_ff == FRAME_BITS && diag_read_frame
			##1 quiet_s |=> diag[4:0] == 5'h0
	) else $error("read clear");
	pdown_a: assert property (
		!up |=> fault_out_n_oe && !gate_enable && !pwm_gated && powered_down
			&& diag == fault_diag_pkg::DIAG_RESET
	) else $error("power down");
	tw_latch_a: assert property (
		diag.thermal_warn_flag && up && !($past(frame_select_n) && !$past(frame_select_n, 2))
			|=> diag.thermal_warn_flag
	) else $error("tw flag lost");
endmodule

bind chip_fault_diagnostics fault_checker #(
	.FRAME_BITS(FRAME_BITS)
) chk (
	.*
);

// >>> testbench.sv
/* self-checking bench for the fault supervision block
   host_model gives pwm, frames and the pin pull-up */
`timescale 1ns/1ps
module testbench;
	logic                   clk = 1'b0;
	logic                   rst = 1'b1;
	fault_diag_pkg::sense_s sense = 4'h1;
	fault_diag_pkg::mask_s  mask = 3'h0;
	logic                   logic_reset_level = 1'b0;
	logic                   direct_mode = 1'b0;
	logic                   stop_on_fault_enable = 1'b0;
	logic                   pwm_in, sck, frame_select_n, diag_read_frame, fault_line;
	fault_diag_pkg::diag_s  diag;
	logic                   fault_out_n_o, fault_out_n_oe, gate_enable;
	logic                   pwm_gated, write_commit, powered_down;
	int                     bad_count = 0;
	int                     num_checks = 0;
	int                     commits = 0;
	int                     errs[3] = '{0, 15, 17};

	chip_fault_diagnostics dut (.*);
	host_model host (.*);

	always #10 clk = ~clk;
	always @(posedge clk) if (write_commit === 1'b1) commits++;

	// ********
	// helpers
	// ********
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
		num_checks++;
		if (seen !== want) begin
			bad_count++;
			$display("BAD %0t %s seen %h want %h", $time, what, seen, want);
		end
	endtask

	task automatic watch(input int n, output int low, output int pw);
		low = 0;
		pw = 0;
		repeat (n) begin
			tick(1);
			low += (fault_line === 1'b0);
			pw += (pwm_gated === 1'b1);
		end
	endtask

	// 0 pin free, 1 steady low, 2 pulsing
	function automatic int want_pin(input logic dm, ef, ot, mk);
		if (mk)
			return 0;
		if (dm || (ot && ef))
			return 1;
		return (ot || ef) ? 2 : 0;
	endfunction

	task automatic close_out;
		$display("checks %0d bad %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		$display("BAD %0t run too long", $time);
		close_out;
	end

	// ********
	// main sequence
	// ********
	initial begin
		int low;
		int pw;
		int win;
		int k;
		logic dm, ef, ot, mk, pat;
		void'($urandom(32'h36da));
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		tick(2);
		check(diag, fault_diag_pkg::DIAG_RESET, "reset");
		host.frame(16, 1'b1);
		tick(1);
		check(diag[4:0], 5'h0, "clear");
		foreach (errs[i]) begin
			k = commits;
			host.frame(errs[i], 1'b0);
			tick(1);
			check({diag.serial_error_flag, diag.general_fault_flag}, 2'h3, "err");
			check(commits == k, 1'b1, "commit");
		end
		host.frame(15, 1'b1);
		tick(1);
		check(diag.serial_error_flag, 1'b1, "kept");
		k = commits;
		host.frame(16, 1'b0);
		tick(1);
		check(commits == k + 1, 1'b1, "commit");
		host.frame(16, 1'b1);
		tick(1);
		$display("serial test done");
		for (int i = 0; i < 16; i++) begin
			{mk, ot, ef, dm} = 4'(i);
			host.half = 2 + $urandom % 2;
			win = 32 * host.half;
			mask = {mk & ~ot, mk & ot, 1'b0};
			direct_mode = dm;
			stop_on_fault_enable = ef;
			sense.thermal_warn = ~ot;
			sense.overtemp = ot;
			tick(3 + $urandom % 4);
			watch(win, low, pw);
			k = want_pin(dm, ef, ot, mk);
			pat = k == 0 ? low == 0 : k == 1 ? low == win
				: low >= 14 * host.half - 6 && low <= 18 * host.half + 6;
			check(pat, 1'b1, "pin");
			check(gate_enable, !(ot && !mk && (dm || ef)), "gate");
			check(ot ? diag.overtemp_flag : diag.thermal_warn_flag, !mk, "flag");
			sense.thermal_warn = 1'b0;
			sense.overtemp = 1'b0;
			tick(2);
			if (k == 1)
				check(fault_out_n_oe, 1'b0, "release");
			tick(win);
			check(fault_out_n_oe, 1'b0, "end");
			check(ot ? diag.overtemp_flag : diag.thermal_warn_flag, !mk, "latch");
			host.frame(16, 1'b1);
			tick(1);
			check(diag[4:0], 5'h0, "clear");
		end
		$display("thermal test done");
		for (int m = 0; m < 2; m++) begin
			mask = {2'h0, 1'(m)};
			direct_mode = 1'($urandom);
			sense = 4'h2;
			tick(3);
			watch(8, low, pw);
			check(low == 8, m == 0, "uv pin");
			check(pw > 0, m == 1, "uv pwm");
			check(diag.supply_undervoltage_flag, m == 0, "uv flag");
			sense = 4'h0;
			tick(3);
			check(fault_out_n_oe, m == 0, "uv hold");
			sense = 4'h1;
			tick(3);
			check({fault_out_n_oe, gate_enable}, 2'h1, "uv end");
			check(diag.supply_undervoltage_flag, m == 0, "uv latch");
			host.frame(16, 1'b1);
			tick(1);
		end
		$display("uv test done");
		mask = 3'h0;
		logic_reset_level = 1'b1;
		tick(3);
		check(diag, fault_diag_pkg::DIAG_RESET, "pd flags");
		check({fault_out_n_oe, gate_enable, pwm_gated, powered_down}, 4'h9, "pd");
		logic_reset_level = 1'b0;
		tick(3);
		check({diag, powered_down}, {fault_diag_pkg::DIAG_RESET, 1'b0}, "pu");
		$display("power test done");
		close_out;
	end
endmodule
